// ===== hdl/eii_pkg.sv
// Constants and state types shared by the encoder input interface.
package eii_pkg;

  // Encoder type codes.
  localparam logic ENC_QUADRATURE = 1'b0;
  localparam logic ENC_CLOCK_DIR = 1'b1;

  // Supply select codes: 5 V, 12 V, 15 V, 24 V.
  localparam logic [1:0] SUPPLY_5V = 2'h0;
  localparam logic [1:0] SUPPLY_12V = 2'h1;
  localparam logic [1:0] SUPPLY_15V = 2'h2;
  localparam logic [1:0] SUPPLY_24V = 2'h3;
  localparam logic [1:0] SUPPLY_RESET = SUPPLY_5V;

  // Lines per revolution limits and reset value.
  localparam int LINES_W = 17;
  localparam logic [16:0] LINES_MIN = 17'h0_0001;
  localparam logic [16:0] LINES_MAX = 17'h1_86A0;
  localparam logic [16:0] LINES_RESET = 17'h0_0800;

  // Counted edges per line in each decoding mode.
  localparam logic [2:0] EDGES_QUAD = 3'h4;
  localparam logic [2:0] EDGES_CD = 3'h1;

  // Clock rate and speed gate timing.
  localparam int CLK_MHZ = 250;
  localparam int GATE_TIME_US = 10000;
  localparam int US_PER_MIN = 60000000;

  // Divider widths.
  localparam int NUM_W = 48;
  localparam int DEN_W = 20;
  localparam int CNT_W = 6;

  // State of the decoder and speed gate.
  typedef struct packed {
    logic a_last;
    logic b_last;
    logic [31:0] pos;
    logic [31:0] win_cnt;
    logic [31:0] win_edges;
    logic [31:0] speed;
    logic neg;
    logic speed_valid;
    logic dir_up;
    logic fault;
    logic [1:0] supply;
    logic div_go;
  } eii_state_s;

  // State of the serial divider.
  typedef struct packed {
    logic [NUM_W-1:0] num_sh;
    logic [DEN_W:0] rem;
    logic [DEN_W-1:0] den;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } eii_div_s;

endpackage : eii_pkg

// ===== hdl/eii_divider.sv
// Serial restoring divider used for the speed calculation.
`timescale 1ns/1ps

module eii_divider (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [eii_pkg::NUM_W-1:0] numer,
  input wire logic [eii_pkg::DEN_W-1:0] denom,
  output logic busy,
  output logic done,
  output logic [31:0] quot
);

  eii_pkg::eii_div_s d_reg;
  eii_pkg::eii_div_s d_next;
  logic [eii_pkg::DEN_W:0] rem_sh;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // One quotient bit per cycle; a start while busy is ignored.
  always_comb begin
    d_next = d_reg;
    d_next.done = 1'b0;
    rem_sh = {d_reg.rem[eii_pkg::DEN_W-1:0],
              d_reg.num_sh[eii_pkg::NUM_W-1]};
    take = (rem_sh >= {1'b0, d_reg.den});
    if (d_reg.busy) begin
      d_next.rem = take ? rem_sh - {1'b0, d_reg.den} : rem_sh;
      d_next.num_sh = {d_reg.num_sh[eii_pkg::NUM_W-2:0], take};
      d_next.cnt = d_reg.cnt - 1'b1;
      if (d_reg.cnt == '0) begin
        d_next.busy = 1'b0;
        d_next.done = 1'b1;
      end
    end else if (start) begin
      d_next.num_sh = numer;
      d_next.den = denom;
      d_next.rem = '0;
      d_next.cnt = 6'(eii_pkg::NUM_W - 1);
      d_next.busy = 1'b1;
    end
  end

  // Register with clock enable freezing everything.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      d_reg <= '0;
    end else if (clk_en) begin
      d_reg <= d_next;
    end
  end

  // Quotient saturates at 0x7FFF_FFFF, the signed 32-bit maximum; real speeds never get near it.
  assign busy = d_reg.busy;
  assign done = d_reg.done;
  assign quot = (d_reg.num_sh[eii_pkg::NUM_W-1:31] != '0) ?
                32'h7FFF_FFFF : d_reg.num_sh[31:0];

endmodule : eii_divider

// ===== hdl/eii_top.sv
// Incremental encoder input: decoding, position count and speed in RPM.
`timescale 1ns/1ps

// Functional notes
// - Encoder type zero decodes quadrature, one decodes pulse and direction, quadrature after reset.
// - With invert set the counting direction is reversed; invert is off by default.
// - Lines per revolution, 1 to 100000 with 2048 as default, scales the pulse rate into speed.
// - Single-ended mode uses only the true channels, otherwise differential pairs are expected.
// - A two-bit supply select picks 5, 12, 15 or 24 V, with code zero after reset.
// - A signed 32-bit position counter steps up or down on each decoded pulse.
module eii_top #(
  parameter int GATE_US = eii_pkg::GATE_TIME_US
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic chan_a_p,
  input wire logic chan_a_n,
  input wire logic chan_b_p,
  input wire logic chan_b_n,
  input wire logic enc_type,
  input wire logic invert,
  input wire logic single_ended,
  input wire logic [16:0] lines_per_rev,
  input wire logic [1:0] supply_sel_in,
  input wire logic count_reset,
  output logic [1:0] supply_sel,
  output logic [31:0] position,
  output logic [31:0] speed_rpm,
  output logic speed_valid,
  output logic dir_up,
  output logic pair_fault
);

  // Gate length in cycles, and RPM per edge-per-gate factor.
  localparam int GATE_CYC = GATE_US * eii_pkg::CLK_MHZ;
  localparam int RPM_SCALE = eii_pkg::US_PER_MIN / GATE_US;

  eii_pkg::eii_state_s st_reg;
  eii_pkg::eii_state_s st_next;
  logic a_chg;
  logic b_chg;
  logic step;
  logic up_raw;
  logic up;
  logic [16:0] lines_eff;
  logic [2:0] edge_mult;
  logic [31:0] edges_abs;
  logic [eii_pkg::NUM_W-1:0] div_num;
  logic [eii_pkg::DEN_W-1:0] div_den;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;

  ////////////////////////////////////////////////////////////////////////////
  // Line count clamped to its legal range so a bad setting never divides by
  // zero; the count of edges per line depends on the decoding mode.
  always_comb begin
    if (lines_per_rev < eii_pkg::LINES_MIN) begin
      lines_eff = eii_pkg::LINES_MIN;
    end else if (lines_per_rev > eii_pkg::LINES_MAX) begin
      lines_eff = eii_pkg::LINES_MAX;
    end else begin
      lines_eff = lines_per_rev;
    end
    edge_mult = (enc_type == eii_pkg::ENC_CLOCK_DIR) ?
                eii_pkg::EDGES_CD : eii_pkg::EDGES_QUAD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge decoding. Quadrature counts every legal gray step and drops a
  // double change, which can only be noise or a missed sample.
  always_comb begin
    a_chg = chan_a_p ^ st_reg.a_last;
    b_chg = chan_b_p ^ st_reg.b_last;
    if (enc_type == eii_pkg::ENC_CLOCK_DIR) begin
      step = chan_a_p & ~st_reg.a_last;
      up_raw = chan_b_p;
    end else begin
      step = a_chg ^ b_chg;
      up_raw = chan_a_p ^ st_reg.b_last;
    end
    up = up_raw ^ invert;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: position, gate window, speed and settings.
  always_comb begin
    st_next = st_reg;
    st_next.div_go = 1'b0;
    st_next.a_last = chan_a_p;
    st_next.b_last = chan_b_p;
    st_next.supply = supply_sel_in;
    // Complement inputs only matter for differential wiring.
    st_next.fault = !single_ended &&
                    ((chan_a_p == chan_a_n) || (chan_b_p == chan_b_n));
    if (count_reset) begin
      st_next.pos = '0;
    end else if (step) begin
      st_next.pos = up ? st_reg.pos + 32'h0000_0001 :
                    st_reg.pos - 32'h0000_0001;
    end
    if (step) begin
      st_next.dir_up = up;
    end
    if (st_reg.win_cnt == '0) begin
      // Gate closes: hand its edge count to the divider and restart.
      st_next.win_cnt = 32'(GATE_CYC - 1);
      st_next.neg = st_reg.win_edges[31];
      st_next.win_edges = step ? (up ? 32'h0000_0001 : 32'hFFFF_FFFF) : '0;
    end else begin
      st_next.win_cnt = st_reg.win_cnt - 32'h0000_0001;
      // Start is raised one cycle early so that the divider loads the count
      // of the closing gate, before the restart overwrites it.
      st_next.div_go = (st_reg.win_cnt == 32'h0000_0001) && !div_busy;
      if (step) begin
        st_next.win_edges = up ? st_reg.win_edges + 32'h0000_0001 :
                            st_reg.win_edges - 32'h0000_0001;
      end
    end
    if (div_done) begin
      st_next.speed = st_reg.neg ? 32'(-div_quot) : div_quot;
      st_next.speed_valid = 1'b1;
    end
  end

  // State register; clock enable low freezes all of it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed: edges per gate times RPM scale over edges per revolution.
  assign edges_abs = st_reg.win_edges[31] ? 32'(-st_reg.win_edges) :
                     st_reg.win_edges;
  assign div_num = eii_pkg::NUM_W'(edges_abs) *
                   eii_pkg::NUM_W'(RPM_SCALE);
  assign div_den = eii_pkg::DEN_W'(lines_eff) *
                   eii_pkg::DEN_W'(edge_mult);

  // Operands are sampled on the cycle the divider starts.
  eii_divider u_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .start(st_reg.div_go),
    .numer(div_num),
    .denom(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // Outputs come straight from the state register.
  assign supply_sel = st_reg.supply;
  assign position = st_reg.pos;
  assign speed_rpm = st_reg.speed;
  assign speed_valid = st_reg.speed_valid;
  assign dir_up = st_reg.dir_up;
  assign pair_fault = st_reg.fault;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the decoder, counter and settings.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_cd_rise;
    clk_en && !count_reset && enc_type && !st_reg.a_last && chan_a_p;
  endsequence

  sequence s_quad_fwd;
    clk_en && !count_reset && !enc_type && !invert &&
    !st_reg.a_last && !st_reg.b_last && chan_a_p && !chan_b_p;
  endsequence

  a_cd_rise_count: assert property (
    s_cd_rise |=> position == (($past(chan_b_p) ^ $past(invert)) ?
      $past(position) + 32'h0000_0001 : $past(position) - 32'h0000_0001))
    else $error("pulse edge did not step the position");

  a_quad_fwd_step: assert property (
    s_quad_fwd |=> position == $past(st_reg.pos) + 32'h0000_0001 && dir_up)
    else $error("quadrature forward step not counted up");

  a_invert_flip: assert property (
    clk_en && !count_reset && step && invert |=>
      position == ($past(up_raw) ? $past(position) - 32'h0000_0001 :
                   $past(position) + 32'h0000_0001))
    else $error("invert did not reverse the count");

  a_pos_idle_hold: assert property (
    clk_en && !count_reset && chan_a_p == st_reg.a_last &&
    chan_b_p == st_reg.b_last |=> $stable(position))
    else $error("position moved without an edge");

  a_count_clear: assert property (
    clk_en && count_reset |=> position == 32'h0000_0000)
    else $error("count reset did not clear the position");

  a_single_no_fault: assert property (
    clk_en && single_ended |=> !pair_fault)
    else $error("complement inputs used in single-ended mode");

  a_diff_fault: assert property (
    clk_en && !single_ended && chan_a_p == chan_a_n |=> pair_fault)
    else $error("missing differential pair not flagged");

  a_supply_follow: assert property (
    clk_en |=> supply_sel == $past(supply_sel_in))
    else $error("supply select did not follow its setting");

  a_lines_range: assert property (
    lines_eff >= eii_pkg::LINES_MIN && lines_eff <= eii_pkg::LINES_MAX)
    else $error("line count outside its legal range");

endmodule : eii_top

// ===== tb/eii_enc_model.sv
// Behavioural incremental encoder that drives both channel pairs.
`timescale 1ns/1ps

module eii_enc_model (
  input wire logic sys_clk,
  input wire logic mode,
  input wire logic step,
  input wire logic up,
  input wire logic se,
  input wire logic bad,
  output logic a_p,
  output logic a_n,
  output logic b_p,
  output logic b_n
);
  logic [1:0] ph = 2'h0;
  logic junk = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // The phase moves off the sampling edge, one position per request.
  always @(negedge sys_clk) begin
    junk <= ~junk;
    if (step) begin
      ph <= up ? ph + 2'h1 : ph - 2'h1;
    end
  end

  // Gray order puts A ahead of B when counting up; in pulse mode bit 0 is
  // the pulse and B carries the direction level.
  assign a_p = mode ? ph[0] : ph[0] ^ ph[1];
  assign b_p = mode ? up : ph[1];
  // Complements left unwired in single-ended use float, so they toggle.
  assign a_n = bad ? a_p : (se ? junk : ~a_p);
  assign b_n = se ? ~junk : ~b_p;
endmodule : eii_enc_model

// ===== tb/eii_top_tb_top.sv
// Self-checking bench for the encoder input interface.
`timescale 1ns/1ps

module eii_top_tb_top;
  localparam int GATE = 4;
  localparam int WIN = GATE * eii_pkg::CLK_MHZ;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic enc_type = 1'b0;
  logic invert = 1'b0;
  logic single_ended = 1'b0;
  logic count_reset = 1'b0;
  logic step = 1'b0;
  logic up = 1'b1;
  logic bad = 1'b0;
  logic [16:0] lines = eii_pkg::LINES_RESET;
  logic [1:0] sup_in = 2'h0;
  logic [1:0] supply_sel;
  logic [31:0] position, speed_rpm;
  logic speed_valid, dir_up, pair_fault, a_p, a_n, b_p, b_n;
  logic [31:0] seed = 32'h0000_69b2;
  logic [31:0] exp_pos = 32'h0000_0000;
  logic exp_dir = 1'b0;
  logic [1:0] ph = 2'h0;
  int err_count = 0;
  int n_compared = 0;

  //////////////////////////////////////////////////////////////////////////
  // Clock, design and encoder; clock enable drops only in the freeze test.
  always #2 sys_clk = ~sys_clk;

  eii_top #(.GATE_US(GATE)) u_eii_top (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .chan_a_p(a_p), .chan_a_n(a_n), .chan_b_p(b_p), .chan_b_n(b_n),
    .enc_type(enc_type), .invert(invert), .single_ended(single_ended),
    .lines_per_rev(lines), .supply_sel_in(sup_in),
    .count_reset(count_reset), .supply_sel(supply_sel),
    .position(position), .speed_rpm(speed_rpm),
    .speed_valid(speed_valid), .dir_up(dir_up), .pair_fault(pair_fault)
  );

  eii_enc_model u_eii_enc_model (
    .sys_clk(sys_clk), .mode(enc_type), .step(step), .up(up),
    .se(single_ended), .bad(bad), .a_p(a_p), .a_n(a_n), .b_p(b_p),
    .b_n(b_n)
  );

  //////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected speed, truncated and saturated like a signed 32-bit result.
  function automatic logic [31:0] exp_speed(longint e, longint l, longint m,
                                            logic neg);
    longint q;
    q = e * (eii_pkg::US_PER_MIN / GATE) / (l * m);
    if (q > 64'h0000_0000_7fff_ffff) q = 64'h0000_0000_7fff_ffff;
    return neg ? -q[31:0] : q[31:0];
  endfunction : exp_speed

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////////
  // One encoder request, then count, direction and pair checks. Pulse
  // mode counts only when the pulse bit of the phase rises.
  task automatic do_op(logic s, logic u, logic inv, logic se, logic bd);
    logic hit;
    hit = s && (!enc_type || !ph[0]);
    step <= s;
    up <= u;
    invert <= inv;
    single_ended <= se;
    bad <= bd;
    if (hit) begin
      exp_pos = (u ^ inv) ? exp_pos + 32'h0000_0001 : exp_pos - 32'h0000_0001;
      exp_dir = u ^ inv;
    end
    if (s) ph = u ? ph + 2'h1 : ph - 2'h1;
    @(negedge sys_clk);
    step <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("position", exp_pos, position);
    if (hit) chk("dir_up", 32'(exp_dir), 32'(dir_up));
    chk("pair_fault", 32'(!se && bd), 32'(pair_fault));
  endtask : do_op

  // Clock enable low freezes the count; the held edge lands once it is back.
  task automatic frz_op();
    logic [31:0] held;
    held = exp_pos;
    clk_en <= 1'b0;
    step <= 1'b1;
    up <= 1'b1;
    invert <= 1'b0;
    if (!enc_type || !ph[0]) exp_pos = exp_pos + 32'h0000_0001;
    ph = ph + 2'h1;
    @(negedge sys_clk);
    step <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("position", held, position);
    clk_en <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("position", exp_pos, position);
  endtask : frz_op

  // Mode changes happen under count clear so the formula swap never counts.
  task automatic set_mode(logic md);
    count_reset <= 1'b1;
    enc_type <= md;
    repeat (3) @(negedge sys_clk);
    count_reset <= 1'b0;
    exp_pos = '0;
    repeat (2) @(negedge sys_clk);
    chk("position", exp_pos, position);
  endtask : set_mode

  // Steady stepping over three gates; 3*WIN steps leave the phase intact.
  task automatic spd(logic md, logic [16:0] l, logic u);
    set_mode(md);
    lines <= l;
    up <= u;
    invert <= 1'b0;
    step <= 1'b1;
    repeat (3 * WIN) @(negedge sys_clk);
    chk("speed_rpm", exp_speed(md ? WIN / 2 : WIN, l, md ? eii_pkg::EDGES_CD
        : eii_pkg::EDGES_QUAD, !u), speed_rpm);
    step <= 1'b0;
    @(negedge sys_clk);
  endtask : spd

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge sys_clk);
    chk("supply_sel", '0, 32'(supply_sel));
    chk("position", '0, position);
    chk("speed_valid", '0, 32'(speed_valid));
    @(negedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      sup_in <= 2'(i);
      repeat (2) @(negedge sys_clk);
      chk("supply_sel", 32'(i), 32'(supply_sel));
    end
    for (int md = 0; md < 2; md++) begin
      set_mode(1'(md));
      do_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      do_op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      do_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      frz_op();
      repeat (150) begin
        r = xs();
        do_op(r[0] | r[1], r[2], r[3], r[4], r[5]);
      end
    end
    spd(1'b0, eii_pkg::LINES_RESET, 1'b1);
    spd(1'b0, eii_pkg::LINES_MAX, 1'b0);
    spd(1'b1, eii_pkg::LINES_RESET, 1'b1);
    spd(1'b0, eii_pkg::LINES_MIN, 1'b1);
    chk("speed_valid", 32'h0000_0001, 32'(speed_valid));
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of about 13000 cycles.
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule : eii_top_tb_top
